// ===== acc_pkg.sv
// Constants and types for the analog comparator control block.
// Assumes an 8-bit register port and a single system clock.
package acc_pkg;

  // Register offsets on the register port
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h30; // Comparator control and status
  localparam logic [7:0] OFF_CONV_CTRL_B = 8'h7b; // Converter control B
  localparam logic [7:0] OFF_BUF_DISABLE = 8'h7f; // Pin input buffer disable

  // Bit positions, control and status register
  localparam int BIT_PWR_OFF  = 7; // Comparator power off
  localparam int BIT_BANDGAP  = 6; // Bandgap on positive input
  localparam int BIT_RESULT   = 5; // Synchronised result, read only
  localparam int BIT_FLAG     = 4; // Event flag, write one to clear
  localparam int BIT_IRQ_EN   = 3; // Comparator interrupt enable
  localparam int BIT_CAPTURE  = 2; // Capture link enable
  localparam int BIT_MODE_HI  = 1; // Event mode high bit
  localparam int BIT_MODE_LO  = 0; // Event mode low bit

  // Bit positions, converter control B
  localparam int BIT_NEG_MUX  = 6; // Negative mux enable
  localparam int BIT_TRIG_HI  = 2; // Converter trigger select, top bit

  // Bit positions, buffer disable register
  localparam int BIT_NEG_BUF  = 1; // Negative pin buffer off
  localparam int BIT_POS_BUF  = 0; // Positive pin buffer off

  // Event modes
  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'b00,
    MODE_RESERVED = 2'b01,
    MODE_FALL     = 2'b10,
    MODE_RISE     = 2'b11
  } acc_mode_t;

  // Whole state of the control module
  typedef struct packed {
    logic       power_off;   // Comparator powered down
    logic       bandgap;     // Positive input from bandgap
    logic       flag;        // Sticky event flag
    logic       irq_en;      // Comparator interrupt enable
    logic       capture_en;  // Route result to capture front end
    acc_mode_t  mode;        // Event mode
    logic       neg_mux_en;  // Negative mux enable
    logic [2:0] trig_sel;    // Converter trigger select, stored only
    logic [1:0] buf_off;     // Pin buffer disables
    logic       prev;        // Previous synchronised sample
    logic [7:0] rdata;       // Read data, one cycle after strobe
    logic       irq;         // Interrupt request
    logic       neg_use;     // Negative input from converter channel
    logic [2:0] neg_chan;    // Converter channel for negative input
    logic       capture_out; // Result towards capture front end
    logic [1:0] pin_rd;      // Port input bits seen by software
  } acc_state_t;

  // Value after reset
  localparam acc_state_t ACC_STATE_RST = '0;

  // Synchroniser state
  typedef struct packed {
    logic [2:0] stage1; // First stage, read by second only
    logic [2:0] stage2; // Second stage, usable output
  } acc_sync_t;

  localparam acc_sync_t ACC_SYNC_RST = '0;

endpackage : acc_pkg

// ===== acc_sync.sv
// Two-stage synchroniser for the comparator output and the two pins.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
module acc_sync import acc_pkg::*; (
  input  wire logic       clk_sys,  // System clock
  input  wire logic       reset_n,  // Synchronous reset, active low
  input  wire logic [2:0] async_in, // Asynchronous levels
  output logic      [2:0] sync_out  // Synchronised levels
);

  acc_sync_t st_ff;  // Registered state
  acc_sync_t nxt_st; // Next state

  // Shift the levels through two stages
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.stage1 = async_in;
    nxt_st.stage2 = st_ff.stage1;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_ff <= ACC_SYNC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Only the second stage leaves the module
  assign sync_out = st_ff.stage2;

endmodule : acc_sync

// ===== acc_ctrl.sv
// Control and event logic around an on-chip voltage comparator.
// Assumes the analog comparator, converter and timer capture live outside;
// converter enable, channel select and the global enable share clk_sys.
//
// What this block does
// - Result high when positive input exceeds negative
// - Mux enable, converter off: channel picks negative
// - Bandgap select replaces positive pin input
// - Result synchronised, one to two cycles late
// - Selected output event sets the flag
// - Mode 00 toggle, 01 reserved, 10 fall, 11 rise
// - Flag cleared by vector or write one
// - Interrupt needs flag, enable, global enable
// - Capture link routes result to timer
// - Power-off bit settable any time
// - Buffer off forces port input to zero
// - Unused bits read zero, ignore writes
`timescale 1ns/10ps
module acc_ctrl import acc_pkg::*; (
  input  wire logic       clk_sys,              // System clock, 10 MHz
  input  wire logic       reset_n,              // Synchronous reset, active low
  input  wire logic [7:0] reg_addr,             // Register address
  input  wire logic [7:0] reg_wdata,            // Write data
  input  wire logic       reg_wr,               // Write strobe
  input  wire logic       reg_rd,               // Read strobe
  output logic      [7:0] reg_rdata,            // Read data, cycle after strobe
  input  wire logic       comp_raw,             // Raw analog comparator output
  input  wire logic [1:0] pin_raw,              // Digital levels of the two pins
  input  wire logic       converter_on,         // Converter switched on
  input  wire logic [2:0] channel_select,       // Converter channel select
  input  wire logic       global_irq_enable,    // Core global interrupt enable
  input  wire logic       irq_vector_taken,     // Comparator vector taken, pulse
  output logic            comparator_result,    // Synchronised comparator output
  output logic            comparator_power_off, // Power down to analog part
  output logic            bandgap_select,       // Bandgap on positive input
  output logic            neg_channel_en,       // Negative input from channel
  output logic      [2:0] neg_channel,          // Channel for negative input
  output logic            comparator_irq,       // Interrupt request
  output logic            capture_link_out,     // Result towards capture logic
  output logic      [1:0] pin_buffer_off,       // Pin digital buffer disables
  output logic      [1:0] port_pin_read         // Port input bits for software
);

  acc_state_t st_ff;     // Registered state
  acc_state_t nxt_st;    // Next state
  logic [2:0] sync_lv;   // Synchronised comparator and pins
  logic       res;       // Synchronised comparator result
  logic       evt;       // Selected event this cycle
  logic       wr_csr;    // Write to control and status
  logic       clr_flag;  // Flag clear request this cycle
  logic [7:0] rd_val;    // Read mux value

  // Register address match, used for writes and reads
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // Event decode from mode and two samples
  function automatic logic event_of(input acc_mode_t m, input logic cur,
                                    input logic old);
    case (m)
      MODE_TOGGLE:   event_of = cur ^ old;
      MODE_FALL:     event_of = old & ~cur;
      MODE_RISE:     event_of = cur & ~old;
      MODE_RESERVED: event_of = 1'b0;
      default:       event_of = 1'b0;         // Unreachable codes stay quiet
    endcase
  endfunction : event_of

  // Comparator output and pins cross into the clock domain here
  acc_sync u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({pin_raw, comp_raw}),
    .sync_out (sync_lv)
  );

  // Result bit follows the analog compare, one to two cycles late
  assign res = sync_lv[0];

  // Edge against the stored previous sample; one event per transition
  assign evt = event_of(st_ff.mode, res, st_ff.prev);

  // Write decode for the control and status register
  assign wr_csr = reg_wr && hit(reg_addr, OFF_CTRL_STATUS);

  // Clear by vector or by writing one; zero written leaves it
  assign clr_flag = irq_vector_taken || (wr_csr && reg_wdata[BIT_FLAG]);

  // Read mux; unused bits are constant zero
  always_comb begin
    rd_val = 8'h00;
    if (hit(reg_addr, OFF_CTRL_STATUS)) begin
      rd_val[BIT_PWR_OFF] = st_ff.power_off;
      rd_val[BIT_BANDGAP] = st_ff.bandgap;
      rd_val[BIT_RESULT]  = res;
      rd_val[BIT_FLAG]    = st_ff.flag;
      rd_val[BIT_IRQ_EN]  = st_ff.irq_en;
      rd_val[BIT_CAPTURE] = st_ff.capture_en;
      rd_val[BIT_MODE_HI:BIT_MODE_LO] = st_ff.mode;
    end else if (hit(reg_addr, OFF_CONV_CTRL_B)) begin
      rd_val[BIT_NEG_MUX]      = st_ff.neg_mux_en;
      rd_val[BIT_TRIG_HI:0]    = st_ff.trig_sel;
    end else if (hit(reg_addr, OFF_BUF_DISABLE)) begin
      rd_val[BIT_NEG_BUF:BIT_POS_BUF] = st_ff.buf_off;
    end else begin
      rd_val = 8'h00; // Unmapped address reads zero
    end
  end

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;

    // Register writes; read-only and unused bits ignore data
    if (wr_csr) begin
      nxt_st.power_off  = reg_wdata[BIT_PWR_OFF];
      nxt_st.bandgap    = reg_wdata[BIT_BANDGAP];
      nxt_st.irq_en     = reg_wdata[BIT_IRQ_EN];
      nxt_st.capture_en = reg_wdata[BIT_CAPTURE];
      nxt_st.mode       = acc_mode_t'(reg_wdata[BIT_MODE_HI:BIT_MODE_LO]);
    end
    if (reg_wr && hit(reg_addr, OFF_CONV_CTRL_B)) begin
      nxt_st.neg_mux_en = reg_wdata[BIT_NEG_MUX];
      nxt_st.trig_sel   = reg_wdata[BIT_TRIG_HI:0];
    end
    if (reg_wr && hit(reg_addr, OFF_BUF_DISABLE)) begin
      nxt_st.buf_off = reg_wdata[BIT_NEG_BUF:BIT_POS_BUF];
    end

    // Sticky flag; an event in the clearing cycle still wins
    nxt_st.flag = (st_ff.flag && !clr_flag) || evt;

    // Keep the sample for the next edge compare
    nxt_st.prev = res;

    // Read data only in the cycle after the strobe
    nxt_st.rdata = reg_rd ? rd_val : 8'h00;

    // Request from the updated flag so a cleared flag drops it at once
    nxt_st.irq = nxt_st.flag && st_ff.irq_en && global_irq_enable;

    // Negative input selection follows enable and converter state
    nxt_st.neg_use  = st_ff.neg_mux_en && !converter_on;
    nxt_st.neg_chan = channel_select;

    // No connection to capture logic while the link is off
    nxt_st.capture_out = st_ff.capture_en && res;

    // Disabled buffers make the port bit read as zero
    nxt_st.pin_rd = sync_lv[2:1] & ~st_ff.buf_off;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_ff <= ACC_STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata            = st_ff.rdata;
  assign comparator_result    = sync_lv[0];
  assign comparator_power_off = st_ff.power_off;
  assign bandgap_select       = st_ff.bandgap;
  assign neg_channel_en       = st_ff.neg_use;
  assign neg_channel          = st_ff.neg_chan;
  assign comparator_irq       = st_ff.irq;
  assign capture_link_out     = st_ff.capture_out;
  assign pin_buffer_off       = st_ff.buf_off;
  assign port_pin_read        = st_ff.pin_rd;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Toggle mode flags any change of the sample
  a_toggle_sets_flag: assert property (
    (st_ff.mode == MODE_TOGGLE && res != st_ff.prev) |=> st_ff.flag
  ) else $error("toggle did not set flag");

  // Falling mode flags a one-to-zero step
  a_fall_sets_flag: assert property (
    (st_ff.mode == MODE_FALL && st_ff.prev && !res) |=> st_ff.flag
  ) else $error("falling edge did not set flag");

  // Rising mode ignores falling steps
  a_rise_ignores_fall: assert property (
    (st_ff.mode == MODE_RISE && !st_ff.flag && st_ff.prev && !res)
      |=> !st_ff.flag
  ) else $error("rising mode flagged a fall");

  // Reserved mode never raises the flag
  a_reserved_quiet: assert property (
    (st_ff.mode == MODE_RESERVED && !st_ff.flag) |=> !st_ff.flag
  ) else $error("reserved mode set flag");

  // One transition, one event: a steady sample gives none
  a_steady_no_event: assert property (
    (res == st_ff.prev) |-> !evt
  ) else $error("event without transition");

  // Write one clears the flag unless an event lands
  a_write_one_clears: assert property (
    (wr_csr && reg_wdata[BIT_FLAG] && !evt) |=> !st_ff.flag
  ) else $error("write one did not clear flag");

  // Write zero keeps the flag
  a_write_zero_keeps: assert property (
    (st_ff.flag && wr_csr && !reg_wdata[BIT_FLAG] && !irq_vector_taken)
      |=> st_ff.flag
  ) else $error("write zero cleared flag");

  // Vector taken clears the flag, event aside
  a_vector_clears: assert property (
    (irq_vector_taken && !evt) |=> !st_ff.flag
  ) else $error("vector did not clear flag");

  // Request only with flag and both enables
  a_irq_gated: assert property (
    comparator_irq |-> (st_ff.flag && $past(st_ff.irq_en)
                        && $past(global_irq_enable))
  ) else $error("interrupt without its conditions");

  // Negative channel chosen only with mux on and converter off
  a_neg_select: assert property (
    1'b1 |=> neg_channel_en == $past(st_ff.neg_mux_en && !converter_on)
  ) else $error("negative input selection wrong");

  // No capture output while the link is off
  a_capture_off: assert property (
    !st_ff.capture_en |=> !capture_link_out
  ) else $error("capture output with link off");

  // Both buffers disabled read zero on both port bits
  a_buffer_zero: assert property (
    (st_ff.buf_off[BIT_POS_BUF] && st_ff.buf_off[BIT_NEG_BUF])
      |=> port_pin_read == 2'b00
  ) else $error("disabled pin reads nonzero");

  // Unused bits of converter control B read zero
  a_unused_zero: assert property (
    (reg_rd && hit(reg_addr, OFF_CONV_CTRL_B))
      |=> (reg_rdata[7] == 1'b0 && reg_rdata[5:3] == 3'h0)
  ) else $error("unused bits read nonzero");

  // Read data stands only in the cycle after the strobe
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00
  ) else $error("read data outside its cycle");

  // Main scenarios
  c_rise_flag:    cover property (st_ff.mode == MODE_RISE && evt ##1 st_ff.flag);
  c_fall_flag:    cover property (st_ff.mode == MODE_FALL && evt ##1 st_ff.flag);
  c_irq_raised:   cover property (!comparator_irq ##1 comparator_irq);
  c_vector_clear: cover property (st_ff.flag && irq_vector_taken ##1 !st_ff.flag);

endmodule : acc_ctrl

// ===== acc_analog_model.sv
// Behavioural model of the analog side: pins, channels, bandgap, comparator.
// Assumes voltages in millivolts set directly by the testbench.
`timescale 1ns/10ps
module acc_analog_model #(
  parameter int BG_MV = 1100 // Bandgap level, plain default
) (
  input  wire logic       power_off,      // Comparator powered down
  input  wire logic       bandgap_select, // Bandgap on positive input
  input  wire logic       neg_channel_en, // Negative input from channel
  input  wire logic [2:0] neg_channel,    // Channel for negative input
  input  int              pos_mv,         // Positive pin level
  input  int              neg_mv,         // Negative pin level
  input  int              chan_mv [8],    // Converter channel levels
  output logic            comp_raw        // Raw comparator output
);
  int pos_in; // Level seen at positive input
  int neg_in; // Level seen at negative input

  // Input selection and compare; output held low when unpowered
  always_comb begin
    pos_in   = bandgap_select ? BG_MV : pos_mv;
    neg_in   = neg_channel_en ? chan_mv[neg_channel] : neg_mv;
    comp_raw = !power_off && (pos_in > neg_in);
  end
endmodule : acc_analog_model

// ===== tb_top.sv
// Self-checking testbench for the comparator control block.
// Assumes the analog model drives comp_raw from testbench voltages.
`timescale 1ns/10ps
module tb_top import acc_pkg::*; ;
  logic       clk_sys = 1'b0;    // System clock, 100 ns
  logic       reset_n = 1'b0;    // Synchronous reset, active low
  logic [7:0] reg_addr = 8'h00;  // Register address
  logic [7:0] reg_wdata = 8'h00; // Write data
  logic       reg_wr = 1'b0;     // Write strobe
  logic       reg_rd = 1'b0;     // Read strobe
  logic [7:0] reg_rdata;         // Read data
  logic       comp_raw;          // From analog model
  logic [1:0] pin_raw = 2'b11;   // Pin digital levels
  logic       converter_on = 1'b0;
  logic [2:0] channel_select = 3'h0;
  logic       global_irq_enable = 1'b0;
  logic       irq_vector_taken = 1'b0;
  logic       comparator_result, comparator_power_off, bandgap_select;
  logic       neg_channel_en, comparator_irq, capture_link_out;
  logic [2:0] neg_channel;
  logic [1:0] pin_buffer_off, port_pin_read;
  int         pos_mv = 500;      // Positive pin level
  int         neg_mv = 800;      // Negative pin level
  int         chan_mv [8] = '{default: 100};
  int         fail_count = 0;    // Mismatches
  int         check_count = 0;   // Comparisons made
  int         cycles = 0;        // Timeout counter

  // Device under test
  acc_ctrl i_acc_ctrl (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comp_raw(comp_raw), .pin_raw(pin_raw), .converter_on(converter_on),
    .channel_select(channel_select), .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken), .comparator_result(comparator_result),
    .comparator_power_off(comparator_power_off), .bandgap_select(bandgap_select),
    .neg_channel_en(neg_channel_en), .neg_channel(neg_channel),
    .comparator_irq(comparator_irq), .capture_link_out(capture_link_out),
    .pin_buffer_off(pin_buffer_off), .port_pin_read(port_pin_read));

  // Far side: analog inputs and comparator
  acc_analog_model i_acc_analog_model (.power_off(comparator_power_off),
    .bandgap_select(bandgap_select), .neg_channel_en(neg_channel_en),
    .neg_channel(neg_channel), .pos_mv(pos_mv), .neg_mv(neg_mv),
    .chan_mv(chan_mv), .comp_raw(comp_raw));

  // Clock generation
  always #50 clk_sys = ~clk_sys;

  // Hang guard; the tests need far fewer cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // Register write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1; // Later voltage steps land clear of the synchroniser's edge
  endtask : wr

  // Compare and report
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Register read; data stands only in the cycle after the strobe
  task automatic chkr(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask : chkr

  // Wait whole cycles, then step clear of the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt

  // Closing report
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Test sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    chkr("ctrl reset", OFF_CTRL_STATUS, 8'h00);
    chkr("convb reset", OFF_CONV_CTRL_B, 8'h00);
    $display("test reset done");
    // Every event mode, interrupt kept off while changing it
    pos_mv = 300;
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL_STATUS, 8'h10 | 8'(m));
      pos_mv = 900;
      wt(5);
      chkr("flag rise", OFF_CTRL_STATUS, {3'b001, m == 0 || m == 3, 2'b00, 2'(m)});
      wr(OFF_CTRL_STATUS, 8'h10 | 8'(m));
      pos_mv = 300;
      wt(5);
      chkr("flag fall", OFF_CTRL_STATUS, {3'b000, m == 0 || m == 2, 2'b00, 2'(m)});
    end
    $display("test modes done");
    // Interrupt gating and flag clearing
    global_irq_enable <= 1'b1;
    wr(OFF_CTRL_STATUS, 8'h1b);
    pos_mv = 900;
    wt(5);
    chk("irq set", 8'h01, {7'h00, comparator_irq});
    global_irq_enable <= 1'b0;
    wt(2);
    chk("irq gie off", 8'h00, {7'h00, comparator_irq});
    global_irq_enable <= 1'b1;
    wt(2);
    chk("irq gie on", 8'h01, {7'h00, comparator_irq});
    @(posedge clk_sys);
    irq_vector_taken <= 1'b1;
    @(posedge clk_sys);
    irq_vector_taken <= 1'b0;
    wt(1);
    chk("irq vector", 8'h00, {7'h00, comparator_irq});
    chkr("flag vector", OFF_CTRL_STATUS, 8'h2b);
    pos_mv = 300;
    wt(4);
    pos_mv = 900;
    wt(5);
    wr(OFF_CTRL_STATUS, 8'h0b);
    chkr("flag write 0", OFF_CTRL_STATUS, 8'h3b);
    wr(OFF_CTRL_STATUS, 8'h1b);
    chkr("flag write 1", OFF_CTRL_STATUS, 8'h2b);
    wr(OFF_CTRL_STATUS, 8'h10);
    $display("test irq done");
    // Unused bits, unmapped address, pin buffers
    wr(OFF_CONV_CTRL_B, 8'hff);
    chkr("convb bits", OFF_CONV_CTRL_B, 8'h47);
    wr(OFF_BUF_DISABLE, 8'hff);
    chkr("bufdis bits", OFF_BUF_DISABLE, 8'h03);
    wr(8'h31, 8'hff);
    chkr("unmapped", 8'h31, 8'h00);
    wt(4);
    chk("pins off", 8'h00, {6'h00, port_pin_read});
    chk("buffers off", 8'h03, {6'h00, pin_buffer_off});
    wr(OFF_BUF_DISABLE, 8'h01);
    wt(4);
    chk("pins partial", 8'h02, {6'h00, port_pin_read});
    $display("test regs done");
    // Negative input from each converter channel
    pos_mv = 500;
    neg_mv = 400;
    for (int k = 0; k < 8; k++) begin
      channel_select <= 3'(k);
      chan_mv[k] = 1000;
      wt(6);
      chk("neg chan", {4'h0, 1'b1, 3'(k)}, {4'h0, neg_channel_en, neg_channel});
      chk("chan result", 8'h00, {7'h00, comparator_result});
      chan_mv[k] = 100;
    end
    converter_on <= 1'b1;
    wt(6);
    chk("conv on", 8'h01, {6'h00, neg_channel_en, comparator_result});
    $display("test mux done");
    // Bandgap on positive input
    pos_mv = 300;
    neg_mv = 800;
    wr(OFF_CTRL_STATUS, 8'h40);
    wt(5);
    chk("bandgap", 8'h03, {6'h00, bandgap_select, comparator_result});
    wr(OFF_CTRL_STATUS, 8'h00);
    wt(5);
    chk("pin pos", 8'h00, {6'h00, bandgap_select, comparator_result});
    // Capture link follows result only when enabled
    wr(OFF_CTRL_STATUS, 8'h04);
    pos_mv = 900;
    wt(5);
    chk("capture hi", 8'h01, {7'h00, capture_link_out});
    pos_mv = 300;
    wt(5);
    chk("capture lo", 8'h00, {7'h00, capture_link_out});
    wr(OFF_CTRL_STATUS, 8'h00);
    pos_mv = 900;
    wt(5);
    chk("capture off", 8'h00, {7'h00, capture_link_out});
    // Power off from a live result
    wr(OFF_CTRL_STATUS, 8'h80);
    wt(5);
    chk("power off", 8'h01, {7'h00, comparator_power_off});
    // Power-down drops the output; toggle mode flags that step
    chkr("power read", OFF_CTRL_STATUS, 8'h90);
    $display("test misc done");
    finish_test();
  end
endmodule : tb_top
